// file: design/dqc_map.vh
// Register offsets, field positions and timing counts of the acquisition card host-port logic
`ifndef DQC_MAP_VH
`define DQC_MAP_VH

`define DQC_OFF_AD_LOW        4'h4
`define DQC_OFF_AD_HIGH       4'h5
`define DQC_OFF_DAC_LOW       4'h4
`define DQC_OFF_DAC_HIGH      4'h5
`define DQC_OFF_DIN_LOW       4'h6
`define DQC_OFF_DIN_HIGH      4'h7
`define DQC_OFF_INT_CLEAR     4'h8
`define DQC_OFF_PACER_ONE     4'h9
`define DQC_OFF_PACER_TWO     4'hA
`define DQC_OFF_MODE          4'hB
`define DQC_OFF_SOFT_TRIG     4'hC
`define DQC_OFF_DOUT_LOW      4'hD
`define DQC_OFF_DOUT_HIGH     4'hE

`define DQC_MODE_SOFT_POLL    3'h0
`define DQC_MODE_EXT_POLL     3'h2
`define DQC_MODE_EXT_INT      3'h3
`define DQC_MODE_PACER_POLL   3'h4
`define DQC_MODE_PACER_INT    3'h6
`define DQC_MODE_LSB          0
`define DQC_MODE_MSB          2

`define DQC_READY_BIT         4
`define DQC_MODE_RESET        3'h0
`define DQC_DIV_RESET         16'h0002
`define DQC_DIV_MIN           16'h0002

`define DQC_CLK_MHZ           20
`define DQC_PACER_MHZ         2
`define DQC_CONV_TIME_US      8
`define DQC_CONV_CYCLES       (`DQC_CONV_TIME_US * `DQC_CLK_MHZ)
`define DQC_PACER_PRESCALE    (`DQC_CLK_MHZ / `DQC_PACER_MHZ)

`endif

// file: design/dqc_down_counter.v
// Reloading 16-bit down-counter used as one stage of the pacer divider
`timescale 1ns/1ps
`default_nettype none
module dqc_down_counter #(
  parameter WIDTH = 16
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire             tick,
  input  wire [WIDTH-1:0] divisor,
  input  wire             restart,
  output wire             terminal
);
  reg [WIDTH-1:0] count_q;
  reg [WIDTH-1:0] count_d;

  assign terminal = tick && (count_q == {{(WIDTH-1){1'b0}}, 1'b1});

  always @* begin
    count_d = count_q;
    if (restart || terminal || count_q == {WIDTH{1'b0}}) begin
      count_d = divisor;
    end else if (tick) begin
      count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= {WIDTH{1'b0}};
    end else begin
      count_q <= count_d;
    end
  end
endmodule // dqc_down_counter
`default_nettype wire

// file: design/dqc_host_port.v
// Host-port logic: A/D triggering, ready status, interrupt, digital I/O and DAC code
// What this block does
// - In mode 000, any write to the software-trigger offset while idle starts one conversion; data ignored.
// - Digital inputs read as two bytes, bits 7..0 low offset, 15..8 next.
// - Digital outputs driven from two write-only bytes, low then high offset.
// - DAC low write loads code 7..0; high write loads 11..8 from data 3..0.
// - DAC output updates with all 12 bits only on the high-byte write.
// - Ready flag clears during conversion and returns to 1 when it completes.
// - Reading the result low byte clears the ready flag.
// - Mode register selects trigger source together with polling or interrupt transfer.
// - Mode codes 000, 010, 011, 100, 110 valid; other codes unused.
// - Pacer triggers come from two cascaded down-counters clocked at 2 MHz.
// - Each pacer divisor accepts up to 65535; minimum total division four.
// - In external modes a rising edge on input bit 0 starts a conversion.
// - Each conversion completes within 8 microseconds of its trigger.
// - In interrupt modes the interrupt request rises at a conversion end and stays high until the clear port is written.
// - Interrupt status flag set per conversion in modes 011 and 110; host write to clear port clears it.
`timescale 1ns/1ps
`default_nettype none
`include "dqc_map.vh"
module dqc_host_port #(
  parameter CONV_CYCLES = `DQC_CONV_CYCLES,
  parameter PRESCALE    = `DQC_PACER_PRESCALE
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [3:0]  io_addr,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata,
  input  wire [15:0] digital_in_bits,
  output wire [15:0] digital_out_bits,
  output wire [11:0] dac_code_bits,
  output wire        adc_start,
  input  wire        adc_done,
  input  wire [11:0] adc_result_bits,
  output wire        conversion_busy,
  output wire        irq_request
);
  localparam CONV_W = 16;

  reg  [15:0] dout_q;
  reg  [7:0]  dac_stage_q;
  reg  [11:0] dac_out_q;
  reg  [2:0]  op_mode_select_q;
  reg  [15:0] pacer_divisor_one_q;
  reg  [15:0] pacer_divisor_two_q;
  reg  [11:0] result_q;
  reg         conversion_ready_flag_q;
  reg         busy_q;
  reg  [CONV_W-1:0] conv_cnt_q;
  reg         irq_status_q;
  reg         ext_prev_q;
  reg  [7:0]  prescale_q;
  reg         div_lsb_q;
  reg         div_sel_q;

  wire        wr_hit_soft;
  wire        wr_hit_clear;
  wire        ext_rise;
  wire        pacer_tick;
  wire        stage_one_out;
  wire        pacer_trigger;
  wire        trigger;
  wire        conv_end;
  wire        int_mode;
  wire        pacer_restart;

  function wr_at;
    input [3:0] off;
    begin
      wr_at = io_wr && (io_addr == off);
    end
  endfunction

  function [1:0] mode_source;
    input [2:0] m;
    begin
      case (m)
        `DQC_MODE_SOFT_POLL:   mode_source = 2'h1;
        `DQC_MODE_EXT_POLL,
        `DQC_MODE_EXT_INT:     mode_source = 2'h2;
        `DQC_MODE_PACER_POLL,
        `DQC_MODE_PACER_INT:   mode_source = 2'h3;
        default:               mode_source = 2'h0;
      endcase
    end
  endfunction

  assign wr_hit_soft  = wr_at(`DQC_OFF_SOFT_TRIG);
  assign wr_hit_clear = wr_at(`DQC_OFF_INT_CLEAR);
  // Mode register picks source and transfer method; unused codes trigger nothing
  assign int_mode = (op_mode_select_q == `DQC_MODE_EXT_INT) ||
                    (op_mode_select_q == `DQC_MODE_PACER_INT);
  // Inputs are synchronous, so a one-flop history is enough for the edge
  assign ext_rise = digital_in_bits[0] && !ext_prev_q &&
                    (mode_source(op_mode_select_q) == 2'h2);
  assign pacer_tick    = (prescale_q == 8'h00);
  assign pacer_restart = wr_at(`DQC_OFF_MODE) || wr_at(`DQC_OFF_PACER_ONE) ||
                         wr_at(`DQC_OFF_PACER_TWO);
  assign trigger = (wr_hit_soft && mode_source(op_mode_select_q) == 2'h1) ||
                   ext_rise ||
                   (pacer_trigger && mode_source(op_mode_select_q) == 2'h3);
  // Converter either answers adc_done or the fixed budget runs out
  assign conv_end = busy_q && (adc_done ||
                    conv_cnt_q == CONV_CYCLES[CONV_W-1:0] - {{(CONV_W-1){1'b0}}, 1'b1});

  assign adc_start        = trigger && !busy_q;
  assign conversion_busy  = busy_q;
  assign digital_out_bits = dout_q;
  assign dac_code_bits    = dac_out_q;
  assign irq_request      = irq_status_q;

  // 2 MHz tick from the 20 MHz clock
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale_q <= 8'h00;
    end else if (pacer_tick) begin
      prescale_q <= PRESCALE[7:0] - 8'h01;
    end else begin
      prescale_q <= prescale_q - 8'h01;
    end
  end

  // Two cascaded stages: rate is 2 MHz / (divisor one * divisor two)
  dqc_down_counter #(
    .WIDTH    (16)
  ) u_stage_one (
    .clk      (clk),
    .rst_b    (rst_b),
    .tick     (pacer_tick),
    .divisor  (pacer_divisor_one_q),
    .restart  (pacer_restart),
    .terminal (stage_one_out)
  );

  dqc_down_counter #(
    .WIDTH    (16)
  ) u_stage_two (
    .clk      (clk),
    .rst_b    (rst_b),
    .tick     (stage_one_out),
    .divisor  (pacer_divisor_two_q),
    .restart  (pacer_restart),
    .terminal (pacer_trigger)
  );

  // Host writes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_q              <= 16'h0000;
      dac_stage_q         <= 8'h00;
      dac_out_q           <= 12'h000;
      op_mode_select_q    <= `DQC_MODE_RESET;
      pacer_divisor_one_q <= `DQC_DIV_RESET;
      pacer_divisor_two_q <= `DQC_DIV_RESET;
      div_lsb_q           <= 1'b0;
      div_sel_q           <= 1'b0;
    end else if (io_wr) begin
      case (io_addr)
        `DQC_OFF_DOUT_LOW:  dout_q[7:0]  <= io_wdata;
        `DQC_OFF_DOUT_HIGH: dout_q[15:8] <= io_wdata;
        `DQC_OFF_DAC_LOW:   dac_stage_q  <= io_wdata;
        // Low byte written first keeps the output to one clean step
        `DQC_OFF_DAC_HIGH:  dac_out_q    <= {io_wdata[3:0], dac_stage_q};
        `DQC_OFF_MODE:      op_mode_select_q <= io_wdata[`DQC_MODE_MSB:`DQC_MODE_LSB];
        `DQC_OFF_PACER_ONE: begin
          // Divisor loads as two bytes, low first; below 2 is clamped
          div_sel_q <= ~div_sel_q;
          if (!div_sel_q) begin
            pacer_divisor_one_q[7:0] <= io_wdata;
          end else if ({io_wdata, pacer_divisor_one_q[7:0]} < `DQC_DIV_MIN) begin
            pacer_divisor_one_q <= `DQC_DIV_MIN;
          end else begin
            pacer_divisor_one_q[15:8] <= io_wdata;
          end
        end
        `DQC_OFF_PACER_TWO: begin
          div_lsb_q <= ~div_lsb_q;
          if (!div_lsb_q) begin
            pacer_divisor_two_q[7:0] <= io_wdata;
          end else if ({io_wdata, pacer_divisor_two_q[7:0]} < `DQC_DIV_MIN) begin
            pacer_divisor_two_q <= `DQC_DIV_MIN;
          end else begin
            pacer_divisor_two_q[15:8] <= io_wdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Conversion sequencing and status
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q                  <= 1'b0;
      conv_cnt_q              <= {CONV_W{1'b0}};
      result_q                <= 12'h000;
      conversion_ready_flag_q <= 1'b0;
      irq_status_q            <= 1'b0;
      ext_prev_q              <= 1'b0;
    end else begin
      ext_prev_q <= digital_in_bits[0];
      if (adc_start) begin
        busy_q                  <= 1'b1;
        conv_cnt_q              <= {CONV_W{1'b0}};
        conversion_ready_flag_q <= 1'b0;
      end else if (conv_end) begin
        busy_q                  <= 1'b0;
        result_q                <= adc_result_bits;
        conversion_ready_flag_q <= 1'b1;
      end else begin
        conv_cnt_q <= busy_q ? conv_cnt_q + {{(CONV_W-1){1'b0}}, 1'b1} : conv_cnt_q;
        if (io_rd && io_addr == `DQC_OFF_AD_LOW) begin
          conversion_ready_flag_q <= 1'b0;
        end
      end
      // A new end wins over a clear in the same cycle; no new request until cleared
      if (conv_end && int_mode) begin
        irq_status_q <= 1'b1;
      end else if (wr_hit_clear) begin
        irq_status_q <= 1'b0;
      end
    end
  end

  // Read data is registered one cycle after io_rd
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      case (io_addr)
        `DQC_OFF_AD_LOW:   io_rdata <= result_q[7:0];
        `DQC_OFF_AD_HIGH:  io_rdata <= {3'h0, conversion_ready_flag_q, result_q[11:8]};
        `DQC_OFF_DIN_LOW:  io_rdata <= digital_in_bits[7:0];
        `DQC_OFF_DIN_HIGH: io_rdata <= digital_in_bits[15:8];
        default:           io_rdata <= 8'h00;
      endcase
    end
  end
endmodule // dqc_host_port
`default_nettype wire

// file: dv/dqc_host_port_properties.sv
// Pin-level checks on the acquisition host-port block
`timescale 1ns/1ps
`default_nettype none
module dqc_props #(
  parameter CONV_CYCLES = 160
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [3:0]  io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic [15:0] digital_in_bits,
  input wire logic [15:0] digital_out_bits,
  input wire logic [11:0] dac_code_bits,
  input wire logic        adc_start,
  input wire logic        conversion_busy,
  input wire logic        irq_request
);
  logic [2:0] mode_q;
  // Mirror of the write-only mode field, needed to qualify triggers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) mode_q <= 3'h0;
    else if (io_wr && io_addr == 4'hB) mode_q <= io_wdata[2:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr(a);
    io_wr && io_addr == a;
  endsequence
  sequence s_eoc;
    // Mode as it stood in the cycle the conversion ended
    $fell(conversion_busy) && ($past(mode_q) == 3'h3 || $past(mode_q) == 3'h6);
  endsequence
  chk_start_busy: assert property (adc_start |=> conversion_busy)
    else $error("start not followed by busy");
  chk_no_retrig: assert property (conversion_busy |-> !adc_start)
    else $error("trigger accepted while busy");
  chk_conv_end: assert property ($rose(conversion_busy) |-> ##[1:161] !conversion_busy)
    else $error("conversion overran its budget");
  chk_soft_start: assert property (s_wr(4'hC) ##0 (!conversion_busy && mode_q == 3'h0)
    |-> adc_start) else $error("soft trigger lost");
  chk_ext_start: assert property ($rose(digital_in_bits[0]) && mode_q[2:1] == 2'b01
    && !conversion_busy |-> adc_start) else $error("edge trigger lost");
  chk_dout_low: assert property (s_wr(4'hD) |=> digital_out_bits[7:0] == $past(io_wdata))
    else $error("low output byte wrong");
  chk_dout_high: assert property (s_wr(4'hE) |=> digital_out_bits[15:8] == $past(io_wdata))
    else $error("high output byte wrong");
  chk_dac_stage: assert property (s_wr(4'h4) |=> $stable(dac_code_bits))
    else $error("code moved on low byte");
  chk_dac_load: assert property (s_wr(4'h5) |=> dac_code_bits[11:8] == $past(io_wdata[3:0]))
    else $error("code high nibble wrong");
  chk_din_read: assert property (io_rd && io_addr == 4'h7 |=> io_rdata == $past(digital_in_bits[15:8]))
    else $error("input high byte wrong");
  chk_irq_clear: assert property (s_wr(4'h8) ##0 !conversion_busy |=> !irq_request)
    else $error("clear port ignored");
  chk_irq_eoc: assert property (s_eoc |-> ##[0:1] irq_request)
    else $error("no request at conversion end");
endmodule // dqc_props
bind dqc_host_port dqc_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (.clk(clk), .rst_b(rst_b),
  .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .digital_in_bits(digital_in_bits), .digital_out_bits(digital_out_bits),
  .dac_code_bits(dac_code_bits), .adc_start(adc_start), .conversion_busy(conversion_busy),
  .irq_request(irq_request));
`default_nettype wire

// file: dv/dqc_host_model.sv
// Host processor model driving the I/O-port strobes
`timescale 1ns/1ps
`default_nettype none
module dqc_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] io_rdata,
  output var  logic [3:0] io_addr,
  output var  logic       io_wr,
  output var  logic       io_rd,
  output var  logic [7:0] io_wdata
);
  initial begin
    io_addr = 4'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wr <= 1'b1;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    io_wdata <= ~d; // Released bus must not keep showing the last byte
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    #1 d = io_rdata;
  endtask
  // Reads without polling: 25 us is 500 cycles
  task automatic late(output logic [7:0] d);
    repeat (500) @(posedge clk);
    rd(4'h4, d);
  endtask
  task automatic clr;
    wr(4'h8, 8'h3C);
  endtask
endmodule // dqc_host_model
`default_nettype wire

// file: dv/dqc_host_port_bench.sv
// Self-checking bench for the acquisition host-port block
`timescale 1ns/1ps
`default_nettype none
module dqc_host_port_bench;
  logic        clk, rst_b, io_wr, io_rd, adc_done, adc_start, conversion_busy, irq_request;
  logic [3:0]  io_addr;
  logic [7:0]  io_wdata, io_rdata, d, lo;
  logic [15:0] din, dout;
  logic [11:0] dac, res, c, exp_dac;
  integer      seed = 32'h93FD, error_cnt = 0, comparisons = 0, starts = 0, cyc = 0;
  integer      dly = 0, i, m, n0, e;
  dqc_host_port dut (.clk(clk), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .digital_in_bits(din),
    .digital_out_bits(dout), .dac_code_bits(dac), .adc_start(adc_start),
    .adc_done(adc_done), .adc_result_bits(res), .conversion_busy(conversion_busy),
    .irq_request(irq_request));
  dqc_host_model host (.clk(clk), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_idle;
    #1;
    for (e = 0; e < 200 && conversion_busy !== 1'b0; e++) @(posedge clk);
    @(posedge clk);
    #1;
  endtask
  // Divisors below two are clamped by the block
  function automatic integer pacer_exp(input integer a, input integer b, input integer t);
    pacer_exp = t / ((a < 2 ? 2 : a) * (b < 2 ? 2 : b) * 10);
  endfunction
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Converter stand-in: random latency well inside the 8 us budget
  always @(posedge clk) begin
    cyc <= cyc + 1;
    adc_done <= (dly == 1);
    if (dly > 0) dly <= dly - 1;
    if (adc_start) begin
      starts <= starts + 1;
      dly <= 10 + {$random(seed)} % 30;
      res <= $random(seed);
    end
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
  end
  initial begin
    rst_b = 1'b0;
    din = 16'h0000;
    adc_done = 1'b0;
    res = 12'h000;
    exp_dac = 12'h000;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++) begin
      din <= $random(seed);
      host.rd(4'h6, d); chk(d, din[7:0]);
      host.rd(4'h7, d); chk(d, din[15:8]);
      lo = $random(seed);
      host.wr(4'hD, lo);
      host.wr(4'hE, ~lo); chk(dout, {~lo, lo});
      c = $random(seed);
      host.wr(4'h4, c[7:0]); chk(dac, exp_dac);
      exp_dac = c;
      host.wr(4'h5, {lo[7:4], c[11:8]}); chk(dac, exp_dac);
    end
    // Bit 0 starts low, so the first rise in the edge modes is a real one
    din <= 16'h0000;
    host.wr(4'hF, 8'h5A);
    host.rd(4'hF, d); chk(d, 16'h0000);
    n0 = starts;
    host.wr(4'hC, 8'hFF);
    host.wr(4'hC, 8'h00);
    host.rd(4'h5, d); chk(d[4], 1'b0);
    wait_idle; chk(starts - n0, 1);
    host.rd(4'h5, d); chk(d, {3'b000, 1'b1, res[11:8]});
    host.rd(4'h4, d); chk(d, res[7:0]);
    host.rd(4'h5, d); chk(d[4], 1'b0);
    host.wr(4'hC, 8'h11);
    host.late(d); chk(d, res[7:0]);
    for (m = 2; m < 4; m++) begin
      host.wr(4'hB, m[7:0]);
      n0 = starts;
      host.wr(4'hC, 8'h00); chk(starts - n0, 0);
      din <= 16'h0001;
      @(posedge clk);
      wait_idle; chk(starts - n0, 1);
      chk(irq_request, m == 3);
      host.clr; chk(irq_request, 1'b0);
      din <= 16'h0000;
    end
    for (i = 0; i < 2; i++) begin
      host.wr(4'h9, i ? 8'h01 : 8'h02);
      host.wr(4'h9, 8'h00);
      host.wr(4'hA, i ? 8'h04 : 8'h03);
      host.wr(4'hA, 8'h00);
      host.wr(4'hB, i ? 8'h06 : 8'h04);
      n0 = starts;
      repeat (1200) @(posedge clk);
      #1;
      m = pacer_exp(i ? 1 : 2, i ? 4 : 3, 1200) - (starts - n0);
      chk(m >= 0 && m <= 1, 1'b1);
      chk(irq_request, i == 1);
      host.wr(4'hB, 8'h00);
      wait_idle;
      host.clr;
    end
    // Unused codes must ignore every source, the still-loaded pacer included
    for (m = 1; m < 8; m = m + 2) begin
      if (m != 3) begin
        host.wr(4'hB, m[7:0]);
        n0 = starts;
        din <= 16'h0001;
        host.wr(4'hC, 8'h00);
        repeat (300) @(posedge clk);
        #1;
        chk(starts - n0, 0);
        chk(irq_request, 1'b0);
        din <= 16'h0000;
      end
    end
    stop_test;
  end
endmodule // dqc_host_port_bench
`default_nettype wire
